/* File: rtl/tkb_pkg.sv */
// Shared constants and types of the touch key burst sequencer.
// Assumes a 40 MHz system clock and an analog front end that
// returns one count per burst.
package tkb_pkg;
  // Clock rate and documented times in their own units
  localparam int CLK_MHZ          = 40;
  localparam int FAST_GAP_US      = 1000;   // Fast spacing, 1 ms
  localparam int LOW_POWER_GAP_US = 85000;  // Low power sleep, 85 ms
  localparam int HEART_US         = 15;     // Floating output pulse
  localparam int MAX_ON_S         = 80;     // Longest detection
  localparam int NOM_BURST_MS     = 21;     // Nominal burst period
  // Derived cycle and burst counts
  localparam logic [21:0] FAST_GAP_CYC = 22'(FAST_GAP_US * CLK_MHZ);
  localparam logic [21:0] LOW_POWER_GAP_CYC =
    22'(LOW_POWER_GAP_US * CLK_MHZ);
  localparam logic [21:0] HEART_CYC = 22'(HEART_US * CLK_MHZ);
  localparam logic [15:0] MAX_ON_BURSTS =
    16'(MAX_ON_S * 1000 / NOM_BURST_MS);
  // Detection figures in counts
  localparam logic [16:0] THRESH   = 17'h0000D;
  localparam logic [16:0] HYST     = 17'h00003;
  localparam logic [2:0]  CONS_LEN = 3'h4;
  // Spread spectrum trim, per mille, and its step spacing
  localparam logic signed [7:0] SPREAD_MAX = 8'sh4B;
  localparam logic [3:0] SPREAD_STEP_CYC = 4'h4;
  // Register byte addresses and drift divider reset values
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_REF    = 4'h4;
  localparam logic [3:0] A_SIG    = 4'h8;
  localparam logic [3:0] A_DRIFT  = 4'hC;
  localparam logic [7:0] FALL_DIV_RST = 8'h01;
  localparam logic [7:0] RISE_DIV_RST = 8'h08;
  // Run modes
  typedef enum logic [1:0] {
    MODE_FAST, MODE_LOW_POWER_RUN, MODE_SYNC
  } tkb_mode_t;
  // One burst result from the front end
  typedef struct packed {
    logic        valid;
    logic [15:0] count;
  } tkb_meas_t;
  // Drift divider settings, bursts per reference step
  typedef struct packed {
    logic [7:0] rise_div;
    logic [7:0] fall_div;
  } tkb_drift_t;
  // Status word layout
  typedef struct packed {
    logic [24:0] zero;
    logic [2:0]  consensus_counter;
    logic        cal_pend;
    logic        active;
    tkb_mode_t   mode;
  } tkb_status_t;
endpackage : tkb_pkg

/* File: rtl/tkb_sequencer.sv */
// Burst sequencer, detection filter and output driver of a
// single touch key. Assumes the front end answers each
// meas_start with one meas.valid pulse on a later clock, and
// that the sync pin is asynchronous to the clock.
// How it works
// (RULE1) Sync high: bursts 1 ms apart
// (RULE2) Sync low: sleep 85 ms after bursts
// (RULE3) Pending touch in low power: fast spacing
// (RULE4) Sync sampled at burst end picks mode
// (RULE5) Host holds sync low beyond burst length
// (RULE6) Sync pulses: burst only on falling edge
// (RULE7) Sync mode sleeps, falling edge wakes burst
// (RULE8) Sync idle past 85 ms leaves sync mode
// (RULE9) Sync mode skips consensus filter
// (RULE10) Timeouts count bursts, not time
// (RULE11) Detect at 13 counts above reference
// (RULE12) Drop out 3 counts below threshold
// (RULE13) Overlong detection forces recalibration
// (RULE14) Four consecutive hits confirm, miss clears
// (RULE15) Recalibrate at reset and on timeout
// (RULE16) Reference drifts only without detection
// (RULE17) Threshold levels follow the reference
// (RULE18) Reference falls faster than it rises
// (RULE19) Oscillator trim swept 7.5 percent in burst
// (RULE20) Output high during detection, low after recal
// (RULE21) Output floats 15 us before each burst
// (RULE22) Recal loads reference, clears filter state
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module tkb_sequencer #(
  parameter logic [21:0] FAST_CYC  = tkb_pkg::FAST_GAP_CYC,
  parameter logic [21:0] SLEEP_CYC = tkb_pkg::LOW_POWER_GAP_CYC,
  parameter logic [15:0] MAX_ON    = tkb_pkg::MAX_ON_BURSTS
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Sync and mode pin
  input  wire logic              sync_pin,
  // Front end handshake
  output logic                   meas_start,
  input  wire tkb_pkg::tkb_meas_t meas,
  output logic signed [7:0]      osc_trim,
  // Output pin
  output logic                   touch_out,
  output logic                   touch_out_oe,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata
);
  // Sequencer states
  typedef enum logic [2:0] {
    ST_HEART, ST_BURST, ST_GAP, ST_SLEEP
  } tkb_state_t;

  // True when sig reaches ref plus the given margin
  function automatic logic above(input logic [15:0] sig,
                                 input logic [15:0] rf,
                                 input logic [16:0] margin);
    above = {1'b0, sig} >= ({1'b0, rf} + margin);
  endfunction : above

  tkb_state_t         state, next_state;     // Sequencer state
  tkb_pkg::tkb_mode_t mode, next_mode;       // Run mode
  logic [21:0]        timer, next_timer;     // Down counter
  logic [2:0]         consensus_counter;     // Consecutive hits
  logic [2:0]         next_consensus_counter;
  logic               active, next_active;   // Confirmed touch
  logic [15:0]        on_cnt, next_on_cnt;   // Bursts while on
  logic [15:0]        ref_lvl, next_ref_lvl; // Drift reference
  logic [7:0]         drift_cnt, next_drift_cnt;
  logic               cal_pend, next_cal_pend;
  logic [15:0]        last_sig, next_last_sig;
  logic               next_meas_start;
  logic signed [7:0]  next_osc_trim;
  logic               trim_up, next_trim_up; // Sweep direction
  logic [3:0]         trim_div, next_trim_div;
  tkb_pkg::tkb_drift_t drift, next_drift;    // Software setting
  logic [31:0]        next_reg_rdata;
  logic               sync_m, sync_s, sync_d; // Synchroniser
  logic               hit;                   // Burst over level
  logic               sync_fall, sync_chg;

  // Two flops before any logic sees the pin, then edge history
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sync_m <= sync_pin;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end
  assign sync_fall = sync_d & ~sync_s;
  assign sync_chg  = sync_d ^ sync_s;

  // Hysteresis: once on, the margin shrinks by the dropout
  assign hit = active ?
    above(meas.count, ref_lvl, tkb_pkg::THRESH - tkb_pkg::HYST) :
    above(meas.count, ref_lvl, tkb_pkg::THRESH); // RULE11 RULE12 RULE17

  // Output floats while the health pulse runs
  assign touch_out    = active;                   // RULE20
  assign touch_out_oe = (state != ST_HEART);      // RULE21

  // Next state of sequencer, filter and drift tracker
  always_comb begin
    next_state             = state;
    next_mode              = mode;
    next_timer             = (timer != 22'h000000) ?
                             timer - 22'h000001 : timer;
    next_consensus_counter = consensus_counter;
    next_active            = active;
    next_on_cnt            = on_cnt;
    next_ref_lvl           = ref_lvl;
    next_drift_cnt         = drift_cnt;
    next_cal_pend          = cal_pend;
    next_last_sig          = last_sig;
    next_meas_start        = 1'b0;
    next_osc_trim          = 8'sh00;
    next_trim_up           = 1'b1;
    next_trim_div          = 4'h0;
    case (state)
      // Floating pulse, then the burst starts
      ST_HEART: begin
        if (timer == 22'h000000) begin
          next_state      = ST_BURST;
          next_meas_start = 1'b1;                 // RULE21
        end
      end
      // Burst: sweep trim, evaluate the result
      ST_BURST: begin
        next_trim_div = trim_div + 4'h1;
        next_trim_up  = trim_up;
        next_osc_trim = osc_trim;
        if (trim_div == tkb_pkg::SPREAD_STEP_CYC - 4'h1) begin
          next_trim_div = 4'h0;
          if (trim_up && osc_trim >= tkb_pkg::SPREAD_MAX)
            next_trim_up = 1'b0;
          else if (!trim_up && osc_trim <= -tkb_pkg::SPREAD_MAX)
            next_trim_up = 1'b1;
          next_osc_trim = next_trim_up ? osc_trim + 8'sh01 :
                          osc_trim - 8'sh01;      // RULE19
        end
        if (meas.valid) begin
          next_osc_trim = 8'sh00;
          next_last_sig = meas.count;
          if (cal_pend) begin
            // Fresh reference, filter state cleared
            next_ref_lvl           = meas.count;  // RULE22 RULE15
            next_consensus_counter = 3'h0;
            next_active            = 1'b0;        // RULE20
            next_on_cnt            = 16'h0000;
            next_drift_cnt         = 8'h00;
            next_cal_pend          = 1'b0;
          end else begin
            if (mode == tkb_pkg::MODE_SYNC) begin
              // Every hit is a detection here
              next_active            = hit;       // RULE9
              next_consensus_counter = 3'h0;
            end else if (!hit) begin
              next_active            = 1'b0;
              next_consensus_counter = 3'h0;      // RULE14
            end else if (!active) begin
              if (consensus_counter == tkb_pkg::CONS_LEN - 3'h1) begin
                next_active            = 1'b1;    // RULE14
                next_consensus_counter = 3'h0;
              end else
                next_consensus_counter = consensus_counter + 3'h1;
            end
            // On-time is measured in bursts
            next_on_cnt = next_active ? on_cnt + 16'h0001 : 16'h0000;
            if (on_cnt >= MAX_ON)
              next_cal_pend = 1'b1;               // RULE13 RULE10
            // Tracking frozen while a touch is on
            if (!active && !next_active) begin    // RULE16
              next_drift_cnt = drift_cnt + 8'h01;
              if (meas.count < ref_lvl) begin
                if (drift_cnt + 8'h01 >= drift.fall_div) begin
                  next_ref_lvl   = ref_lvl - 16'h0001; // RULE18
                  next_drift_cnt = 8'h00;
                end
              end else if (meas.count > ref_lvl) begin
                if (drift_cnt + 8'h01 >= drift.rise_div) begin
                  next_ref_lvl   = ref_lvl + 16'h0001; // RULE18
                  next_drift_cnt = 8'h00;
                end
              end else
                next_drift_cnt = 8'h00;
            end else
              next_drift_cnt = 8'h00;
          end
          // Pin level at burst end steers the mode, except in sync mode
          if (mode == tkb_pkg::MODE_SYNC) begin
            next_state = ST_SLEEP;                // RULE7
            next_timer = SLEEP_CYC - 22'h000001;
          end else begin
            // A low long enough to span the burst is seen here
            if (sync_s)
              next_mode = tkb_pkg::MODE_FAST;     // RULE4 RULE5
            else if (mode == tkb_pkg::MODE_FAST)
              next_mode = tkb_pkg::MODE_SYNC;     // RULE4
            if (next_mode == tkb_pkg::MODE_SYNC) begin
              next_state = ST_SLEEP;
              next_timer = SLEEP_CYC - 22'h000001;
            end else begin
              next_state = ST_GAP;
              // Unresolved touch gets fast spacing
              if (next_mode == tkb_pkg::MODE_FAST ||
                  next_consensus_counter != 3'h0)
                next_timer = FAST_CYC - 22'h000001; // RULE1 RULE3
              else
                next_timer = SLEEP_CYC - 22'h000001; // RULE2
            end
          end
        end
      end
      // Timed gap between bursts
      ST_GAP: begin
        if (timer == 22'h000000) begin
          next_state = ST_HEART;
          next_timer = tkb_pkg::HEART_CYC - 22'h000001;
        end
      end
      // Sync sleep: falling edge wakes, idle pin times out
      ST_SLEEP: begin
        if (sync_chg)
          next_timer = SLEEP_CYC - 22'h000001;    // RULE8
        if (sync_fall) begin
          next_state = ST_HEART;                  // RULE6 RULE7
          next_timer = tkb_pkg::HEART_CYC - 22'h000001;
        end else if (timer == 22'h000000) begin
          next_mode  = sync_s ? tkb_pkg::MODE_FAST :
                       tkb_pkg::MODE_LOW_POWER_RUN; // RULE8
          next_state = ST_HEART;
          next_timer = tkb_pkg::HEART_CYC - 22'h000001;
        end
      end
      default: begin
        next_state = ST_HEART;
        next_timer = tkb_pkg::HEART_CYC - 22'h000001;
      end
    endcase
  end

  // Core registers; reset arms the first calibration
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state             <= ST_HEART;
      mode              <= tkb_pkg::MODE_FAST;
      timer             <= tkb_pkg::HEART_CYC - 22'h000001;
      consensus_counter <= 3'h0;
      active            <= 1'b0;
      on_cnt            <= 16'h0000;
      ref_lvl           <= 16'h0000;
      drift_cnt         <= 8'h00;
      cal_pend          <= 1'b1;                  // RULE15
      last_sig          <= 16'h0000;
      meas_start        <= 1'b0;
      osc_trim          <= 8'sh00;
      trim_up           <= 1'b1;
      trim_div          <= 4'h0;
    end else begin
      state             <= next_state;
      mode              <= next_mode;
      timer             <= next_timer;
      consensus_counter <= next_consensus_counter;
      active            <= next_active;
      on_cnt            <= next_on_cnt;
      ref_lvl           <= next_ref_lvl;
      drift_cnt         <= next_drift_cnt;
      cal_pend          <= next_cal_pend;
      last_sig          <= next_last_sig;
      meas_start        <= next_meas_start;
      osc_trim          <= next_osc_trim;
      trim_up           <= next_trim_up;
      trim_div          <= next_trim_div;
    end
  end

  // Register port decode; unmapped reads give zero
  always_comb begin
    tkb_pkg::tkb_status_t st;
    st                   = '0;
    st.mode              = mode;
    st.active            = active;
    st.cal_pend          = cal_pend;
    st.consensus_counter = consensus_counter;
    next_drift           = drift;
    next_reg_rdata       = 32'h00000000;
    if (reg_wr && reg_addr == tkb_pkg::A_DRIFT)
      next_drift = reg_wdata[15:0];
    if (reg_rd) begin
      case (reg_addr)
        tkb_pkg::A_STATUS: next_reg_rdata = st;
        tkb_pkg::A_REF:    next_reg_rdata = {16'h0000, ref_lvl};
        tkb_pkg::A_SIG:    next_reg_rdata = {16'h0000, last_sig};
        tkb_pkg::A_DRIFT:  next_reg_rdata = {16'h0000, drift};
        default:           next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  // Register port flops; read data stand one cycle only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drift     <= {tkb_pkg::RISE_DIV_RST, tkb_pkg::FALL_DIV_RST};
      reg_rdata <= 32'h00000000;
    end else begin
      drift     <= next_drift;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Length of the floating pulse, counted for a check
  logic [21:0] hb_len;
  always_ff @(posedge clock) begin
    if (sys_rst || touch_out_oe)
      hb_len <= 22'h000000;
    else
      hb_len <= hb_len + 22'h000001;
  end

  property p_heart_len;
    $rose(touch_out_oe) |-> hb_len == tkb_pkg::HEART_CYC;
  endproperty
  a_heart_len: assert property (p_heart_len) // RULE21
    else $error("floating pulse length wrong");

  property p_start_after_heart;
    meas_start |-> touch_out_oe && $past(!touch_out_oe);
  endproperty
  a_start_after_heart: assert property (p_start_after_heart) // RULE21
    else $error("burst start not after floating pulse");

  property p_fast_gap;
    $rose(state == ST_GAP) && mode == tkb_pkg::MODE_FAST
      |-> timer == FAST_CYC - 22'h000001;
  endproperty
  a_fast_gap: assert property (p_fast_gap) // RULE1
    else $error("fast gap length wrong");

  property p_lp_gap;
    $rose(state == ST_GAP) && mode == tkb_pkg::MODE_LOW_POWER_RUN
      |-> timer == ((consensus_counter != 3'h0) ?
          FAST_CYC - 22'h000001 : SLEEP_CYC - 22'h000001);
  endproperty
  a_lp_gap: assert property (p_lp_gap) // RULE2
    else $error("low power gap length wrong");

  property p_sync_wake;
    state == ST_SLEEP && !sync_fall && timer != 22'h000000
      |=> state == ST_SLEEP;
  endproperty
  a_sync_wake: assert property (p_sync_wake) // RULE7
    else $error("burst without falling edge in sync sleep");

  property p_consensus;
    $rose(active) && $past(mode) != tkb_pkg::MODE_SYNC &&
      !$past(cal_pend) |-> $past(consensus_counter) == 3'h3;
  endproperty
  a_consensus: assert property (p_consensus) // RULE14
    else $error("output confirmed without four hits");

  property p_sync_direct;
    state == ST_BURST && meas.valid && !cal_pend && !active &&
      mode == tkb_pkg::MODE_SYNC &&
      above(meas.count, ref_lvl, tkb_pkg::THRESH) |=> active;
  endproperty
  a_sync_direct: assert property (p_sync_direct) // RULE9
    else $error("sync mode hit not detected");

  property p_freeze;
    active && !cal_pend |=> $stable(ref_lvl);
  endproperty
  a_freeze: assert property (p_freeze) // RULE16
    else $error("reference moved during detection");

  property p_trim;
    (osc_trim <= tkb_pkg::SPREAD_MAX &&
      osc_trim >= -tkb_pkg::SPREAD_MAX) and
      (state != ST_BURST |-> osc_trim == 8'sh00);
  endproperty
  a_trim: assert property (p_trim) // RULE19
    else $error("oscillator trim out of range");

  property p_max_on;
    state == ST_BURST && meas.valid && !cal_pend && on_cnt >= MAX_ON
      |=> cal_pend ##1 (cal_pend || !active);
  endproperty
  a_max_on: assert property (p_max_on) // RULE13
    else $error("max on time did not force recalibration");

  c_confirm: cover property ($rose(active) &&
    mode != tkb_pkg::MODE_SYNC);
  c_enter_sync: cover property ($rose(mode == tkb_pkg::MODE_SYNC));
  c_sync_timeout: cover property (state == ST_SLEEP &&
    timer == 22'h000000 && !sync_fall);
  c_recal: cover property ($fell(cal_pend) && $past(on_cnt) != 0);
endmodule : tkb_sequencer

/* File: sim/tkb_front_model.sv */
// Behavioural model of the analog front end behind the sequencer.
// Assumes the bench sets the count and the answer delay ahead of
// each burst; one answer is given per burst request.
`timescale 1ns/1ps
module tkb_front_model (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // Burst request and answer
  input  wire logic               meas_start,
  output tkb_pkg::tkb_meas_t      meas,
  // Bench controls
  input  wire logic [15:0]        resp_count,
  input  wire logic [9:0]         resp_delay
);
  logic       busy;  // Burst in progress
  logic [9:0] left;  // Cycles still to wait
  logic [15:0] last; // Last count handed over

  // Answer after the set delay; idle bus shows the inverse count so
  // a design that reads outside the valid pulse sees garbage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
      left <= '0;
      last <= '0;
      meas <= '0;
    end else begin
      meas.valid <= 1'b0;
      meas.count <= ~last;
      if (meas_start) begin
        busy <= 1'b1;
        left <= resp_delay;
      end else if (busy && left != '0) begin
        left <= left - 10'h001;
      end else if (busy) begin
        busy <= 1'b0;
        meas.valid <= 1'b1;
        meas.count <= resp_count;
        last <= resp_count;
      end
    end
  end
endmodule : tkb_front_model

/* File: sim/tb_top.sv */
// Self-checking bench of the touch key burst sequencer.
// Assumes shortened gap, sleep and max-on parameters.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  localparam int FG = 200;  // Short fast gap
  localparam int SG = 2000; // Short sleep and sync timeout
  localparam int MO = 20;   // Short max-on burst count
  localparam int H  = int'(tkb_pkg::HEART_CYC);
  logic clock, sys_rst, sync_pin, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic meas_start, touch_out, touch_out_oe;
  logic signed [7:0] osc_trim, tmax, tmin;
  tkb_pkg::tkb_meas_t meas;
  logic [15:0] resp_count;
  logic [9:0]  resp_delay;
  int bad_count, checks_done, lo, last_lo, w, n;
  int since, gs; // Cycles since the last answer, gap seen at start

  tkb_sequencer #(.FAST_CYC(22'(FG)), .SLEEP_CYC(22'(SG)),
    .MAX_ON(16'(MO))) i_tkb_sequencer (.clock(clock), .sys_rst(sys_rst),
    .sync_pin(sync_pin), .meas_start(meas_start), .meas(meas),
    .osc_trim(osc_trim), .touch_out(touch_out),
    .touch_out_oe(touch_out_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  tkb_front_model i_tkb_front_model (.clock(clock), .sys_rst(sys_rst),
    .meas_start(meas_start), .meas(meas), .resp_count(resp_count),
    .resp_delay(resp_delay));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Length of each floated stretch and trim extremes of each burst
  always @(posedge clock) begin
    if (sys_rst || meas.valid) since <= 0;
    else since <= since + 1;
    if (sys_rst) begin
      lo <= 0;
      last_lo <= 0;
    end
    else if (!touch_out_oe) lo <= lo + 1;
    else if (lo != 0) begin
      last_lo <= lo;
      lo <= 0;
    end
    if (meas_start) begin
      tmax <= '0;
      tmin <= '0;
    end else begin
      if (osc_trim > tmax) tmax <= osc_trim;
      if (osc_trim < tmin) tmin <= osc_trim;
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // One settled cycle; a wait that runs too long ends the run
  task automatic tick(ref int k);
    @(posedge clock);
    #1;
    k++;
    if (k > 6000) begin
      bad_count++;
      $display("[FAIL] wait exp done got timeout");
      give_verdict();
    end
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Wait for a burst, answer it, return the cycles waited
  task automatic burst(input logic [15:0] c, output int wt);
    int k;
    resp_count <= c;
    wt = 0;
    k = 0;
    while (meas_start !== 1'b1) tick(wt);
    gs = since;
    while (meas.valid !== 1'b1) tick(k);
    tick(k);
    `CHK("heart", H, last_lo)
  endtask : burst

  task automatic gap(input string s, input int wt, input int base);
    `CHK(s, 1'b1, (wt >= base + H - 1 && wt <= base + H + 4))
  endtask : gap

  task automatic quiet(input int q);
    int k;
    k = 0;
    repeat (q) begin
      @(posedge clock);
      #1;
      if (meas_start === 1'b1) k++;
    end
    `CHK("no burst", 0, k)
  endtask : quiet

  initial begin
    sys_rst = 1'b1;
    sync_pin = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    resp_count = 16'h03E8;
    resp_delay = 10'h000;
    {bad_count, checks_done} = '0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    #1 `CHK("oe rst", 1'b0, touch_out_oe)
    rd(tkb_pkg::A_STATUS, d); `CHK("stat", 32'h00000008, d)
    rd(tkb_pkg::A_DRIFT, d); `CHK("drift", 32'h00000801, d)
    rd(4'h2, d); `CHK("unmapped", 32'h00000000, d)
    wr(tkb_pkg::A_REF, 32'h00001234);
    burst(16'h03E8, w);
    rd(tkb_pkg::A_REF, d); `CHK("ref cal", 32'h000003E8, d)
    rd(tkb_pkg::A_STATUS, d); `CHK("stat", 32'h00000000, d)
    wr(tkb_pkg::A_DRIFT, 32'h0000FF01);
    $display("test reset done");
    resp_delay <= 10'h3E8;
    burst(16'h03E8, w); gap("fast gap", gs, FG);
    `CHK("trim hi", tkb_pkg::SPREAD_MAX, tmax)
    `CHK("trim lo", -tkb_pkg::SPREAD_MAX, tmin)
    `CHK("trim idle", 8'sh00, osc_trim)
    resp_delay <= 10'h000;
    repeat (4) burst(16'h03F4, w);
    `CHK("below thr", 1'b0, touch_out)
    repeat (3) burst(16'h03F5, w);
    burst(16'h03E8, w);
    repeat (3) burst(16'h03F5, w);
    `CHK("miss clears", 1'b0, touch_out)
    burst(16'h03F5, w); `CHK("fourth", 1'b1, touch_out)
    burst(16'h03F2, w); `CHK("hyst hold", 1'b1, touch_out)
    rd(tkb_pkg::A_REF, d); `CHK("frozen", 32'h000003E8, d)
    burst(16'h03F1, w); `CHK("hyst drop", 1'b0, touch_out)
    $display("test threshold done");
    repeat (3) burst(16'h03DE, w);
    rd(tkb_pkg::A_REF, d); `CHK("ref fall", 32'h000003E5, d)
    repeat (4) burst(16'h03F2, w);
    `CHK("thr moved", 1'b1, touch_out)
    burst(16'h03E5, w);
    wr(tkb_pkg::A_DRIFT, 32'h00000801);
    repeat (16) burst(16'h03EA, w);
    rd(tkb_pkg::A_REF, d);
    `CHK("ref rise", 1'b1, d[15:0] inside {16'h03E6, 16'h03E7})
    wr(tkb_pkg::A_DRIFT, 32'h0000FF01);
    $display("test drift done");
    repeat (4) burst(16'h0406, w);
    n = 0;
    while (touch_out === 1'b1 && n < 40) begin
      burst(16'h0406, w);
      n++;
    end
    `CHK("max on", 1'b1, (n >= MO - 1 && n <= MO + 4))
    `CHK("out after", 1'b0, touch_out)
    rd(tkb_pkg::A_REF, d); `CHK("recal", 32'h00000406, d)
    $display("test max on done");
    @(posedge clock) sync_pin <= 1'b0;
    burst(16'h0406, w);
    rd(tkb_pkg::A_STATUS, d); `CHK("sync", 2'h2, d[1:0])
    quiet(1000);
    @(posedge clock) sync_pin <= 1'b1;
    quiet(500);
    @(posedge clock) sync_pin <= 1'b0;
    burst(16'h0413, w);
    `CHK("fall wake", 1'b1, (w >= H && w <= H + 8))
    `CHK("no filter", 1'b1, touch_out)
    quiet(300);
    @(posedge clock) sync_pin <= 1'b1;
    quiet(500);
    @(posedge clock) sync_pin <= 1'b0;
    burst(16'h0406, w); `CHK("sync miss", 1'b0, touch_out)
    $display("test sync done");
    burst(16'h0406, w);
    rd(tkb_pkg::A_STATUS, d); `CHK("lp", 2'h1, d[1:0])
    burst(16'h0406, w); gap("lp gap", gs, SG);
    burst(16'h0413, w);
    burst(16'h0406, w); gap("lp hit", gs, FG);
    burst(16'h0406, w); gap("lp back", gs, SG);
    @(posedge clock) sync_pin <= 1'b1;
    burst(16'h0406, w);
    rd(tkb_pkg::A_STATUS, d); `CHK("fast", 2'h0, d[1:0])
    $display("test modes done");
    give_verdict();
  end
endmodule : tb_top
